/* dhp_host_port.v */
/*
 * Host register port of a dual-channel UART with receive DMA request logic.
 * Assumes a UART core beside it supplying receive data, status bytes and
 * receive FIFO state per channel; host strobes are asynchronous and wide.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dhp_map.vh"

// Summary of operation
// - Three address bits pick channel register
// - Divisor-access bit redirects addresses zero, one, two
// - Access only while select is low
// - Channel pick one means channel 0
// - Read falling edge drives data out
// - Write rising edge latches data
// - FIFO setup bit 3 picks DMA type
// - Non-FIFO mode allows only DMA mode 0
// - Mode 0: single transfer requests
// - Mode 1: burst until receive FIFO empty
// - Eight-bit bus driven only during reads
module dhp_host_port (
   input  wire        core_clk,
   input  wire        rst,
   input  wire        reg_addr_2,
   input  wire        reg_addr_1,
   input  wire        reg_addr_0,
   input  wire        cs_n,
   input  wire        channel_pick,
   input  wire        rd_n,
   input  wire        wr_n,
   input  wire [7:0]  host_data_bus_in,
   output reg  [7:0]  host_data_bus_out,
   output reg         host_data_bus_oe,
   input  wire [15:0] rx_data,
   input  wire [15:0] iir_value,
   input  wire [15:0] lsr_value,
   input  wire [15:0] msr_value,
   input  wire [1:0]  rx_not_empty,
   input  wire [1:0]  rx_trigger_hit,
   input  wire [1:0]  rx_timeout,
   output wire [15:0] line_format_reg,
   output wire [15:0] fifo_setup_reg,
   output wire [15:0] divisor_low,
   output wire [15:0] divisor_high,
   output wire [15:0] alt_function,
   output wire [15:0] int_enable,
   output wire [15:0] modem_control,
   output wire [15:0] scratch,
   output wire [1:0]  divisor_access_bit,
   output reg  [7:0]  tx_data,
   output reg  [1:0]  tx_write_pulse,
   output reg  [1:0]  rx_read_pulse,
   output reg  [1:0]  fifo_setup_pulse,
   output wire [1:0]  rx_dma_request_n
);

   // ==========================================================
   // Decode helpers
   function [3:0] target_of;
      input [2:0] addr;
      input       div_access;
      begin
         target_of = {1'b0, addr};
         if (div_access) begin
            case (addr)
               `DHP_ADDR_DATA: target_of = `DHP_TGT_DLL;
               `DHP_ADDR_IER:  target_of = `DHP_TGT_DLM;
               `DHP_ADDR_IIR:  target_of = `DHP_TGT_AFR;
               default:        target_of = {1'b0, addr};
            endcase
         end
      end
   endfunction

   function chan_of;
      input pick;
      begin
         chan_of = (pick == `DHP_CH_FIRST_PICK) ? 1'b0 : 1'b1;
      end
   endfunction

   // ==========================================================
   // Strobe synchronisers
   wire rd_level_n;
   wire rd_fall;
   wire rd_rise;
   wire wr_fall;
   wire wr_rise;

   dhp_strobe_sync u_rd_sync (
      .core_clk   (core_clk),
      .rst        (rst),
      .strobe_n   (rd_n),
      .level_n    (rd_level_n),
      .fall_pulse (rd_fall),
      .rise_pulse (rd_rise)
   );

   dhp_strobe_sync u_wr_sync (
      .core_clk   (core_clk),
      .rst        (rst),
      .strobe_n   (wr_n),
      .level_n    (),
      .fall_pulse (wr_fall),
      .rise_pulse (wr_rise)
   );

   // Address, select and data delayed by the synchroniser depth, so the
   // values used at a strobe edge are those present at the pin edge.
   reg [12:0] ctl_d1_reg;
   reg [12:0] ctl_d2_reg;

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctl_d1_reg <= `DHP_RST_CTL;
         ctl_d2_reg <= `DHP_RST_CTL;
      end else begin
         ctl_d1_reg <= {cs_n, channel_pick, reg_addr_2, reg_addr_1, reg_addr_0,
                        host_data_bus_in};
         ctl_d2_reg <= ctl_d1_reg;
      end
   end

   wire       d_cs_n = ctl_d2_reg[12];
   wire       d_chan = chan_of(ctl_d2_reg[11]);
   wire [2:0] d_addr = ctl_d2_reg[10:8];
   wire [7:0] d_data = ctl_d2_reg[7:0];

   // ==========================================================
   // Per-channel writable registers
   reg [7:0] lfmt_mem   [0:1];
   reg [7:0] fsetup_mem [0:1];
   reg [7:0] dll_mem [0:1];
   reg [7:0] dlm_mem [0:1];
   reg [7:0] afr_mem [0:1];
   reg [7:0] ier_mem [0:1];
   reg [7:0] mcr_mem [0:1];
   reg [7:0] scr_mem [0:1];

   wire [3:0] d_target = target_of(d_addr, lfmt_mem[d_chan][`DHP_DIV_ACCESS_BIT]);

   integer i;

   // Data latched on the trailing edge of the write strobe
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < 2; i = i + 1) begin
            lfmt_mem[i]   <= `DHP_RST_BYTE;
            fsetup_mem[i] <= `DHP_RST_BYTE;
            dll_mem[i] <= `DHP_RST_BYTE;
            dlm_mem[i] <= `DHP_RST_BYTE;
            afr_mem[i] <= `DHP_RST_BYTE;
            ier_mem[i] <= `DHP_RST_BYTE;
            mcr_mem[i] <= `DHP_RST_BYTE;
            scr_mem[i] <= `DHP_RST_BYTE;
         end
         tx_data          <= `DHP_RST_BYTE;
         tx_write_pulse   <= 2'b00;
         fifo_setup_pulse <= 2'b00;
      end else begin
         tx_write_pulse   <= 2'b00;
         fifo_setup_pulse <= 2'b00;
         if (wr_rise && !d_cs_n) begin
            case (d_target)
               `DHP_TGT_DATA: begin
                  tx_data                <= d_data;
                  tx_write_pulse[d_chan] <= 1'b1;
               end
               `DHP_TGT_IER:     ier_mem[d_chan] <= d_data;
               `DHP_TGT_IIR_SETUP: begin
                  fsetup_mem[d_chan]       <= d_data;
                  fifo_setup_pulse[d_chan] <= 1'b1;
               end
               `DHP_TGT_LINE_FMT: lfmt_mem[d_chan] <= d_data;
               `DHP_TGT_MCR:     mcr_mem[d_chan] <= d_data;
               `DHP_TGT_SCR:     scr_mem[d_chan] <= d_data;
               `DHP_TGT_DLL:     dll_mem[d_chan] <= d_data;
               `DHP_TGT_DLM:     dlm_mem[d_chan] <= d_data;
               `DHP_TGT_AFR:     afr_mem[d_chan] <= d_data;
               default: begin
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Read path
   reg [7:0] read_mux;

   always @* begin
      case (d_target)
         `DHP_TGT_DATA:    read_mux = rx_data[d_chan*8 +: 8];
         `DHP_TGT_IER:     read_mux = ier_mem[d_chan];
         `DHP_TGT_IIR_SETUP: read_mux = iir_value[d_chan*8 +: 8];
         `DHP_TGT_LINE_FMT:  read_mux = lfmt_mem[d_chan];
         `DHP_TGT_MCR:     read_mux = mcr_mem[d_chan];
         `DHP_TGT_LSR:     read_mux = lsr_value[d_chan*8 +: 8];
         `DHP_TGT_MSR:     read_mux = msr_value[d_chan*8 +: 8];
         `DHP_TGT_SCR:     read_mux = scr_mem[d_chan];
         `DHP_TGT_DLL:     read_mux = dll_mem[d_chan];
         `DHP_TGT_DLM:     read_mux = dlm_mem[d_chan];
         `DHP_TGT_AFR:     read_mux = afr_mem[d_chan];
         default:          read_mux = `DHP_RST_BYTE;
      endcase
   end

   // Read data is frozen at the leading edge so status cannot shift
   // under the host while it samples.
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         host_data_bus_out <= `DHP_RST_BYTE;
         host_data_bus_oe  <= 1'b0;
         rx_read_pulse     <= 2'b00;
      end else begin
         rx_read_pulse <= 2'b00;
         if (rd_fall && !d_cs_n) begin
            host_data_bus_out <= read_mux;
            host_data_bus_oe  <= 1'b1;
            if (d_target == `DHP_TGT_DATA) begin
               rx_read_pulse[d_chan] <= 1'b1;
            end
         end else if (rd_rise || rd_level_n) begin
            host_data_bus_oe <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Per-channel register outputs and receive DMA request
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_chan
         reg  burst_reg;
         reg  req_n_reg;
         wire fifo_on = fsetup_mem[g][`DHP_SETUP_ENABLE_BIT];
         wire mode1   = fifo_on & fsetup_mem[g][`DHP_SETUP_DMA_BIT];
         wire burst_next = !rx_not_empty[g] ? 1'b0 :
                           ((rx_trigger_hit[g] | rx_timeout[g]) ? 1'b1 : burst_reg);

         always @(posedge core_clk or posedge rst) begin
            if (rst) begin
               burst_reg <= 1'b0;
               req_n_reg <= `DHP_DMA_IDLE_N;
            end else begin
               burst_reg <= mode1 & burst_next;
               if (mode1) begin
                  req_n_reg <= ~burst_next;
               end else begin
                  req_n_reg <= ~rx_not_empty[g];
               end
            end
         end

         assign rx_dma_request_n[g]     = req_n_reg;
         assign divisor_access_bit[g]   = lfmt_mem[g][`DHP_DIV_ACCESS_BIT];
         assign line_format_reg[g*8 +: 8] = lfmt_mem[g];
         assign fifo_setup_reg[g*8 +: 8]  = fsetup_mem[g];
         assign divisor_low[g*8 +: 8]     = dll_mem[g];
         assign divisor_high[g*8 +: 8]    = dlm_mem[g];
         assign alt_function[g*8 +: 8]    = afr_mem[g];
         assign int_enable[g*8 +: 8]      = ier_mem[g];
         assign modem_control[g*8 +: 8]   = mcr_mem[g];
         assign scratch[g*8 +: 8]         = scr_mem[g];
      end
   endgenerate

endmodule

`default_nettype wire

/* dhp_map.vh */
/*
 * Constants for the dual-channel host port: register address codes,
 * internal register targets, bit positions and reset values.
 * Assumes it is included by bare name from the host port design files.
 */
`ifndef DHP_MAP_VH
`define DHP_MAP_VH

// ==========================================================
// Address codes on the three register address inputs
`define DHP_ADDR_DATA      3'h0
`define DHP_ADDR_IER       3'h1
`define DHP_ADDR_IIR       3'h2
`define DHP_ADDR_LINE_FMT  3'h3
`define DHP_ADDR_MCR       3'h4
`define DHP_ADDR_LSR       3'h5
`define DHP_ADDR_MSR       3'h6
`define DHP_ADDR_SCR       3'h7

// ==========================================================
// Internal register targets after divisor-access steering
`define DHP_TGT_DATA       4'h0
`define DHP_TGT_IER        4'h1
`define DHP_TGT_IIR_SETUP  4'h2
`define DHP_TGT_LINE_FMT   4'h3
`define DHP_TGT_MCR        4'h4
`define DHP_TGT_LSR        4'h5
`define DHP_TGT_MSR        4'h6
`define DHP_TGT_SCR        4'h7
`define DHP_TGT_DLL        4'h8
`define DHP_TGT_DLM        4'h9
`define DHP_TGT_AFR        4'ha

// ==========================================================
// Bit positions and reset values
`define DHP_DIV_ACCESS_BIT    7
`define DHP_SETUP_ENABLE_BIT  0
`define DHP_SETUP_DMA_BIT     3
`define DHP_CH_FIRST_PICK  1'b1
`define DHP_RST_BYTE       8'h00
`define DHP_RST_STROBE     1'b1
`define DHP_RST_CTL        13'h1fff
`define DHP_DMA_IDLE_N     1'b1

`endif

/* dhp_strobe_sync.v */
/*
 * Two-flop synchroniser for one active-low host strobe, with edge pulses.
 * Assumes the strobe is idle high and each phase lasts at least three
 * core clock periods.
 */
`timescale 1ns/1ps
`default_nettype none

module dhp_strobe_sync (
   input  wire core_clk,
   input  wire rst,
   input  wire strobe_n,
   output wire level_n,
   output wire fall_pulse,
   output wire rise_pulse
);

   reg meta_reg;
   reg sync_reg;
   reg last_reg;

   // ==========================================================
   // Synchroniser; only sync_reg reads meta_reg
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= `DHP_RST_STROBE;
         sync_reg <= `DHP_RST_STROBE;
         last_reg <= `DHP_RST_STROBE;
      end else begin
         meta_reg <= strobe_n;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // One pulse per edge, so each strobe acts exactly once
   assign level_n    = sync_reg;
   assign fall_pulse = last_reg & ~sync_reg;
   assign rise_pulse = ~last_reg & sync_reg;

endmodule

`default_nettype wire

/* dhp_host_model.sv */
/* Host CPU bus model: drives select, address, channel and strobes, resolves the data bus.
   Assumes the port needs each strobe phase and setup to last three core cycles. */
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] host_data_bus_out,
   input  wire logic       host_data_bus_oe,
   output logic [7:0]      host_data_bus_in,
   output logic [2:0]      addr,
   output logic            cs_n,
   output logic            channel_pick,
   output logic            rd_n,
   output logic            wr_n
);
   logic [7:0] wdata = 8'h00;
   logic       drv = 1'b0;
   // A bus nobody drives shows the inverse of the last data, never a lucky match
   assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : (drv ? wdata : ~wdata);
   initial begin
      {addr, cs_n, channel_pick, rd_n, wr_n} = 7'h0f;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // ==========================================================
   // One access; three cycles of setup before the strobe, six with it low, four of hold after it
   task automatic access(input logic wr, sel_n, ch, input logic [2:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      addr = a;
      cs_n = sel_n;
      channel_pick = ch;
      wdata = d;
      drv = wr;
      cyc(3);
      if (wr) wr_n = 1'b0;
      else rd_n = 1'b0;
      cyc(6);
      q = host_data_bus_in;
      wr_n = 1'b1;
      rd_n = 1'b1;
      cyc(4);
      cs_n = 1'b1;
      drv = 1'b0;
      // Let an edge pass so a following access never reassigns select in one step
      cyc(1);
   endtask
endmodule
`default_nettype wire

/* dhp_host_port_assertions.sv */
/* Checker for the host port pins, write pulses and receive DMA request.
   Assumes the two-stage strobe synchroniser timing of the port. */
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port_chk (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        cs_n,
   input wire logic        channel_pick,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic        host_data_bus_oe,
   input wire logic [15:0] line_format_reg,
   input wire logic [15:0] fifo_setup_reg,
   input wire logic [1:0]  divisor_access_bit,
   input wire logic [1:0]  tx_write_pulse,
   input wire logic [1:0]  rx_not_empty,
   input wire logic [1:0]  rx_dma_request_n
);
   wire burst = fifo_setup_reg[0] & fifo_setup_reg[3];
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // ==========================================================
   chk_read_drives: assert property ($rose(host_data_bus_oe) |-> !$past(rd_n, 2) && !$past(cs_n, 2))
      else $error("bus driven without selected read");
   chk_idle_bus: assert property (rd_n [*6] |-> !host_data_bus_oe)
      else $error("bus driven while idle");
   chk_write_once: assert property (tx_write_pulse[0] |=> !tx_write_pulse[0])
      else $error("write pulse too long");
   chk_write_source: assert property (|tx_write_pulse |-> $past(wr_n, 2) && !$past(cs_n, 2))
      else $error("write without selected strobe");
   chk_write_channel: assert property (|tx_write_pulse |-> tx_write_pulse == {!$past(channel_pick, 2), $past(channel_pick, 2)})
      else $error("write reached wrong channel");
   chk_divisor_mirror: assert property (divisor_access_bit == {line_format_reg[15], line_format_reg[7]})
      else $error("divisor access bit wrong");
   chk_dma_single: assert property (!$past(burst) |-> rx_dma_request_n[0] == !$past(rx_not_empty[0]))
      else $error("single request wrong");
   chk_burst_hold: assert property ($past(burst) && $past(rx_not_empty[0]) && !$past(rx_dma_request_n[0]) |-> !rx_dma_request_n[0])
      else $error("burst request dropped early");
   chk_burst_end: assert property ($past(burst) && !$past(rx_not_empty[0]) |-> rx_dma_request_n[0])
      else $error("burst request kept when empty");
   cover property (tx_write_pulse[1]);
   cover property ($rose(host_data_bus_oe));
   cover property (burst && !rx_dma_request_n[0]);
endmodule
`default_nettype wire

/* tb.sv */
/* Self-checking bench for the host port; the host model drives the pins.
   Assumes constant core status bytes stand in for the UART core. */
`timescale 1ns/1ps
`default_nettype none
`include "dhp_map.vh"
module tb;
   logic        core_clk, rst, cs_n, channel_pick, rd_n, wr_n, host_data_bus_oe;
   logic        reg_addr_2, reg_addr_1, reg_addr_0;
   logic [2:0]  addr;
   logic [7:0]  host_data_bus_in, host_data_bus_out, tx_data, q;
   logic [15:0] rx_data = 16'hc35a, iir_value = 16'h01c1, lsr_value = 16'h2160, msr_value = 16'h5af0;
   logic [15:0] line_format_reg, fifo_setup_reg, divisor_low, divisor_high, alt_function;
   logic [15:0] int_enable, modem_control, scratch;
   logic [1:0]  rx_not_empty, rx_trigger_hit, rx_timeout = 2'b00, divisor_access_bit;
   logic [1:0]  tx_write_pulse, rx_read_pulse, fifo_setup_pulse, rx_dma_request_n;
   int          miscompares = 0, compares = 0, pulses = 0, reads = 0, setups = 0;
   assign {reg_addr_2, reg_addr_1, reg_addr_0} = addr;
   dhp_host_port dut (.*);
   dhp_host_model host (.*);
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      pulses += tx_write_pulse[0];
      reads += rx_read_pulse[0];
      setups += fifo_setup_pulse[0];
   end
   // ==========================================================
   task automatic chk(input string what, input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
      host.access(1'b1, 1'b0, ch, a, d, q);
   endtask
   task automatic rd(input logic ch, input logic [2:0] a);
      host.access(1'b0, 1'b0, ch, a, 8'h00, q);
   endtask
   task automatic summarize;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_channels;
      chk("dma_idle", rx_dma_request_n, 2'b11);
      wr(1'b1, `DHP_ADDR_SCR, 8'ha5);
      wr(1'b0, `DHP_ADDR_SCR, 8'h3c);
      wr(1'b0, `DHP_ADDR_MCR, 8'h1f);
      wr(1'b1, `DHP_ADDR_LSR, 8'hff);
      chk("scratch", scratch, 16'h3ca5);
      chk("modem_control", modem_control, 16'h1f00);
      rd(1'b0, `DHP_ADDR_SCR);
      chk("read_scratch", q, 8'h3c);
      rd(1'b1, `DHP_ADDR_LSR);
      chk("read_line_status", q, 8'h60);
      rd(1'b0, `DHP_ADDR_MSR);
      chk("read_modem_status", q, 8'h5a);
   endtask
   task automatic t_divisor;
      pulses = 0;
      reads = 0;
      wr(1'b1, `DHP_ADDR_LINE_FMT, 8'h83);
      chk("divisor_access", divisor_access_bit, 16'h0001);
      wr(1'b1, `DHP_ADDR_DATA, 8'h12);
      wr(1'b1, `DHP_ADDR_IER, 8'h34);
      wr(1'b1, `DHP_ADDR_IIR, 8'h56);
      chk("divisor", {divisor_high[7:0], divisor_low[7:0]}, 16'h3412);
      chk("alt_function", alt_function, 16'h0056);
      chk("untouched", {int_enable[7:0], fifo_setup_reg[7:0]}, 16'h0000);
      wr(1'b1, `DHP_ADDR_LINE_FMT, 8'h03);
      wr(1'b1, `DHP_ADDR_DATA, 8'h77);
      wr(1'b1, `DHP_ADDR_DATA, 8'h78);
      chk("tx_data", tx_data, 8'h78);
      chk("tx_writes", pulses, 16'h0002);
      rd(1'b1, `DHP_ADDR_DATA);
      chk("read_rx", q, 8'h5a);
      chk("rx_reads", reads, 16'h0001);
   endtask
   task automatic t_nocs;
      host.access(1'b1, 1'b1, 1'b1, `DHP_ADDR_SCR, 8'h00, q);
      chk("deselected_write", scratch, 16'h3ca5);
      host.access(1'b0, 1'b1, 1'b1, `DHP_ADDR_SCR, 8'h00, q);
      chk("deselected_read", q, 8'hff);
   endtask
   task automatic step(input logic ne, th, exp, input string what);
      rx_not_empty = {1'b0, ne};
      rx_trigger_hit = {1'b0, th};
      host.cyc(3);
      chk(what, rx_dma_request_n[0], exp);
   endtask
   task automatic t_dma;
      wr(1'b1, `DHP_ADDR_IIR, 8'h08);
      step(1'b1, 1'b0, 1'b0, "compat_ready");
      step(1'b0, 1'b0, 1'b1, "compat_empty");
      wr(1'b1, `DHP_ADDR_IIR, 8'h09);
      step(1'b1, 1'b0, 1'b1, "burst_wait");
      step(1'b1, 1'b1, 1'b0, "burst_go");
      step(1'b1, 1'b0, 1'b0, "burst_hold");
      step(1'b0, 1'b0, 1'b1, "burst_done");
      rx_timeout = 2'b01;
      step(1'b1, 1'b0, 1'b0, "burst_timeout");
      rx_timeout = 2'b00;
      step(1'b0, 1'b0, 1'b1, "timeout_done");
      wr(1'b1, `DHP_ADDR_IIR, 8'h01);
      step(1'b1, 1'b0, 1'b0, "fifo_single");
      chk("fifo_setups", setups, 16'h0003);
   endtask
   initial begin
      rst = 1'b1;
      rx_not_empty = 2'b00;
      rx_trigger_hit = 2'b00;
      repeat (16) @(posedge core_clk);
      #1 rst = 1'b0;
      chk("line_format", line_format_reg, 16'h0000);
      t_channels;
      t_divisor;
      t_nocs;
      t_dma;
      summarize;
   end
   initial begin
      #20000;
      miscompares++;
      summarize;
   end
endmodule
bind dhp_host_port dhp_host_port_chk chk_i (.core_clk, .rst, .cs_n, .channel_pick, .rd_n,
   .wr_n, .host_data_bus_oe, .line_format_reg, .fifo_setup_reg, .divisor_access_bit,
   .tx_write_pulse, .rx_not_empty, .rx_dma_request_n);
`default_nettype wire
